// >>> design/fswp_core.v
// Status register, write protection and command framing of a serial flash
// Summary of operation
// RULE1 - Write enable sets latch bit S1
// RULE2 - Latch cleared at reset and after writes
// RULE3 - Block-protect bits held at S3, S2
// RULE4 - Block-protect changes only by status write
// RULE5 - Block-protect defaults to zero, nothing protected
// RULE6 - Block-protect locked when lock set, pin low
// RULE7 - Top/bottom selects protection from top or bottom
// RULE8 - Top/bottom locked when lock set, pin low
// RULE9 - Host sends write enable before status write
// RULE10 - Reserved bits S6, S4 read zero
// RULE11 - Host masks reserved bits when testing; the testbench reads with mask ff except the first read in t_lock (mask ac)
// RULE12 - Lock bit at S7, default zero
// RULE13 - Lock clear: pin ignored, latch suffices
// RULE14 - Lock set: pin high needed to write
// RULE15 - Top ranges for block-protect 01, 10
// RULE16 - Bottom ranges; 11 protects whole array
// RULE17 - Program/erase touching protected range ignored
// RULE18 - Command starts at select fall, MSB first
// RULE19 - Command ends at select rise
// RULE20 - Writes aborted unless whole bytes clocked
// RULE21 - While busy only status read accepted
// RULE22 - Busy bit at S0 during write cycles
// RULE23 - Write enable opcode is 06h
// RULE24 - Volatile enable leaves latch, allows volatile write
// RULE25 - Load stored bits before accepting commands
`timescale 1ns/1ps
`default_nettype none
`include "fswp_map.vh"
module fswp_core #(
  parameter NV_CYCLES = `FSWP_NV_CYCLES,
  parameter PROG_CYCLES = `FSWP_NV_CYCLES,
  parameter [3:0] NV_INIT = `FSWP_NV_DEFAULT
) (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // Serial command port pins
  input wire i_sclk,
  input wire i_cs_n,
  input wire i_serial_in,
  input wire i_wp_n,
  // Serial data out
  output reg o_serial_out,
  output wire o_serial_out_oe,
  // Status view and array engine start
  output wire [7:0] o_status,
  output reg o_array_start,
  output reg [7:0] o_array_op,
  output reg [23:0] o_array_addr
);
  // Pins enter through two flops
  wire [3:0] pins_s;
  // Reset levels match idle pins so no false edge follows reset
  fswp_sync #(.W(4), .INIT(4'b0101)) u_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_async({i_sclk, i_cs_n, i_serial_in, i_wp_n}),
    .o_sync(pins_s)
  );
  wire sclk_s = pins_s[3];
  wire cs_n_s = pins_s[2];
  wire din_s = pins_s[1];
  wire wp_n_s = pins_s[0];

  reg sclk_d;
  reg cs_d;
  wire sclk_rise = sclk_s & ~sclk_d;
  wire sclk_fall = ~sclk_s & sclk_d;
  wire cs_fall = ~cs_n_s & cs_d;
  wire cs_rise = cs_n_s & ~cs_d;

  // Edge history
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sclk_d <= 1'b0;
      cs_d <= 1'b1;
    end else begin
      sclk_d <= sclk_s;
      cs_d <= cs_n_s;
    end
  end

  // Non-volatile store and working copies
  reg [3:0] nv_bits; // {lock, tb, bph, bpl}
  reg [3:0] work_bits;
  reg loaded;
  reg write_enable_latch;
  reg vol_en;
  reg busy;
  reg [15:0] busy_cnt;
  reg nv_pending;
  reg [3:0] nv_data;

  wire lock_bit = work_bits[3];
  wire top_bottom_select = work_bits[2];
  wire [1:0] block_protect = work_bits[1:0];

  // Reserved bits forced low
  assign o_status = {lock_bit, 1'b0, top_bottom_select, 1'b0, block_protect, write_enable_latch, busy}; // RULE1 RULE3 RULE10 RULE12 RULE22

  // Framing state
  reg active;
  reg [2:0] bit_cnt;
  reg [7:0] shreg;
  reg [7:0] opcode;
  reg [2:0] byte_cnt;
  reg [23:0] addr;
  reg [7:0] wdata;
  reg ignore;
  reg [7:0] out_sr;
  wire [7:0] next_shreg = {shreg[6:0], din_s}; // RULE18

  // Protection window check
  function prot_hit;
    input [3:0] wb;
    input [23:0] lo;
    input [23:0] hi;
    reg [23:0] plo;
    reg [23:0] phi;
    reg en;
    begin
      en = 1'b1;
      plo = 24'h000000;
      phi = `FSWP_ADDR_TOP;
      case (wb[1:0])
        2'b00: en = 1'b0;
        2'b01: begin
          if (wb[2]) phi = `FSWP_ADDR_Q0; // RULE16
          else plo = `FSWP_ADDR_Q3; // RULE7 RULE15
        end
        2'b10: begin
          if (wb[2]) phi = `FSWP_ADDR_H0; // RULE16
          else plo = `FSWP_ADDR_H2; // RULE15
        end
        default: en = 1'b1;
      endcase
      prot_hit = en && (lo <= phi) && (hi >= plo);
    end
  endfunction

  // Region spanned by the finished command
  reg [23:0] span_lo;
  reg [23:0] span_hi;
  reg is_prog;
  always @* begin
    span_lo = addr;
    span_hi = addr;
    is_prog = 1'b1;
    case (opcode)
      `FSWP_OP_PP: span_hi = addr | `FSWP_SZ_PAGE;
      `FSWP_OP_SE: begin
        span_lo = addr & ~`FSWP_SZ_SECT;
        span_hi = addr | `FSWP_SZ_SECT;
      end
      `FSWP_OP_BE32: begin
        span_lo = addr & ~`FSWP_SZ_B32;
        span_hi = addr | `FSWP_SZ_B32;
      end
      `FSWP_OP_BE64: begin
        span_lo = addr & ~`FSWP_SZ_B64;
        span_hi = addr | `FSWP_SZ_B64;
      end
      `FSWP_OP_CE1, `FSWP_OP_CE2: begin
        span_lo = 24'h000000;
        span_hi = `FSWP_ADDR_TOP;
      end
      default: is_prog = 1'b0;
    endcase
  end

  wire whole_bytes = (bit_cnt == 3'd0); // RULE20
  wire is_addr_op = is_prog && (opcode != `FSWP_OP_CE1) && (opcode != `FSWP_OP_CE2);
  wire need_bytes = is_addr_op ? (byte_cnt >= 3'd4) : (byte_cnt >= 3'd1);
  wire sr_unlocked = ~lock_bit | wp_n_s; // RULE6 RULE8 RULE13 RULE14
  wire fin = active && cs_rise && !ignore && whole_bytes;

  // Serial framing, status and protection decisions
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      nv_bits <= NV_INIT; // RULE5 RULE12
      work_bits <= 4'h0;
      loaded <= 1'b0;
      write_enable_latch <= 1'b0; // RULE2
      vol_en <= 1'b0;
      busy <= 1'b0;
      busy_cnt <= 16'h0000;
      nv_pending <= 1'b0;
      nv_data <= 4'h0;
      active <= 1'b0;
      bit_cnt <= 3'd0;
      shreg <= 8'h00;
      opcode <= 8'h00;
      byte_cnt <= 3'd0;
      addr <= 24'h000000;
      wdata <= 8'h00;
      ignore <= 1'b0;
      o_array_start <= 1'b0;
      o_array_op <= 8'h00;
      o_array_addr <= 24'h000000;
    end else begin
      o_array_start <= 1'b0;
      // Load stored bits once; commands wait for this
      if (!loaded) begin
        work_bits <= nv_bits; // RULE25
        loaded <= 1'b1;
      end
      // Write cycle timer
      if (busy) begin
        if (busy_cnt == 16'h0000) begin
          busy <= 1'b0; // RULE22
          if (nv_pending) nv_bits <= nv_data;
          nv_pending <= 1'b0;
        end else begin
          busy_cnt <= busy_cnt - 16'h0001;
        end
      end
      if (cs_fall && loaded) begin
        active <= 1'b1; // RULE18
        bit_cnt <= 3'd0;
        byte_cnt <= 3'd0;
        ignore <= 1'b0;
      end else if (active && sclk_rise && !cs_n_s) begin
        shreg <= next_shreg;
        bit_cnt <= bit_cnt + 3'd1;
        if (bit_cnt == 3'd7) begin
          if (byte_cnt != 3'd7) byte_cnt <= byte_cnt + 3'd1;
          if (byte_cnt == 3'd0) begin
            opcode <= next_shreg;
            ignore <= busy && (next_shreg != `FSWP_OP_RDSR); // RULE21
          end else if (byte_cnt <= 3'd3) begin
            addr <= {addr[15:0], next_shreg};
          end
          if (byte_cnt == 3'd1) wdata <= next_shreg;
        end
      end
      if (active && cs_rise) begin
        active <= 1'b0; // RULE19
        if (fin && byte_cnt != 3'd0) begin
          case (opcode)
            `FSWP_OP_WREN: begin
              write_enable_latch <= 1'b1; // RULE1 RULE23
              vol_en <= 1'b0;
            end
            `FSWP_OP_VWREN: vol_en <= 1'b1; // RULE24
            `FSWP_OP_WRDI: begin
              write_enable_latch <= 1'b0; // RULE2
              vol_en <= 1'b0;
            end
            `FSWP_OP_WRSR: begin
              if (byte_cnt >= 3'd2 && sr_unlocked && (write_enable_latch || vol_en)) begin // RULE4 RULE13
                work_bits <= {wdata[`FSWP_BIT_SRP], wdata[`FSWP_BIT_TB],
                              wdata[`FSWP_BIT_BPH], wdata[`FSWP_BIT_BPL]};
                if (write_enable_latch) begin
                  nv_data <= {wdata[`FSWP_BIT_SRP], wdata[`FSWP_BIT_TB],
                              wdata[`FSWP_BIT_BPH], wdata[`FSWP_BIT_BPL]};
                  nv_pending <= 1'b1;
                  busy <= 1'b1; // RULE22
                  busy_cnt <= NV_CYCLES[15:0];
                end
                write_enable_latch <= 1'b0; // RULE2
                vol_en <= 1'b0;
              end
            end
            default: begin
              if (is_prog && need_bytes && write_enable_latch) begin
                if (!prot_hit(work_bits, span_lo, span_hi)) begin // RULE17
                  o_array_start <= 1'b1;
                  o_array_op <= opcode;
                  o_array_addr <= addr;
                  busy <= 1'b1;
                  busy_cnt <= PROG_CYCLES[15:0];
                end
                write_enable_latch <= 1'b0; // RULE2
              end
            end
          endcase
        end
      end
    end
  end

  // Status readback shifted out on falling clock, repeating each byte
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      out_sr <= 8'h00;
      o_serial_out <= 1'b0;
    end else if (active && opcode == `FSWP_OP_RDSR && byte_cnt != 3'd0 && sclk_fall) begin
      if (bit_cnt == 3'd0) begin
        o_serial_out <= o_status[7];
        out_sr <= {o_status[6:0], 1'b0};
      end else begin
        o_serial_out <= out_sr[7];
        out_sr <= {out_sr[6:0], 1'b0};
      end
    end
  end
  assign o_serial_out_oe = active && !cs_n_s && (opcode == `FSWP_OP_RDSR) && (byte_cnt != 3'd0);
endmodule // fswp_core
`default_nettype wire

// >>> design/fswp_map.vh
// Constants for the flash status and write-protect block
`ifndef FSWP_MAP_VH
`define FSWP_MAP_VH
// Status bit positions
`define FSWP_BIT_BUSY 0
`define FSWP_BIT_WEL 1
`define FSWP_BIT_BPL 2
`define FSWP_BIT_BPH 3
`define FSWP_BIT_TB 5
`define FSWP_BIT_SRP 7
// Opcodes
`define FSWP_OP_WREN 8'h06
`define FSWP_OP_VWREN 8'h50
`define FSWP_OP_WRDI 8'h04
`define FSWP_OP_RDSR 8'h05
`define FSWP_OP_WRSR 8'h01
`define FSWP_OP_READ 8'h03
`define FSWP_OP_FREAD 8'h0b
`define FSWP_OP_PP 8'h02
`define FSWP_OP_SE 8'h20
`define FSWP_OP_BE32 8'h52
`define FSWP_OP_BE64 8'hd8
`define FSWP_OP_CE1 8'hc7
`define FSWP_OP_CE2 8'h60
// Reset and factory values
`define FSWP_NV_DEFAULT 4'h0
// Protected range bounds
`define FSWP_ADDR_TOP 24'h03ffff
`define FSWP_ADDR_Q3 24'h030000
`define FSWP_ADDR_H2 24'h020000
`define FSWP_ADDR_Q0 24'h00ffff
`define FSWP_ADDR_H0 24'h01ffff
// Erase and program page sizes minus one
`define FSWP_SZ_SECT 24'h000fff
`define FSWP_SZ_B32 24'h007fff
`define FSWP_SZ_B64 24'h00ffff
`define FSWP_SZ_PAGE 24'h0000ff
// Busy time for non-volatile cycles, in microseconds
`define FSWP_T_NV_US 10
`define FSWP_CLK_MHZ 20
`define FSWP_NV_CYCLES (`FSWP_T_NV_US * `FSWP_CLK_MHZ)
`endif

// >>> design/fswp_sync.v
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module fswp_sync #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // Asynchronous levels in, synchronous levels out
  input wire [W-1:0] i_async,
  output reg [W-1:0] o_sync
);
  reg [W-1:0] meta;

  // First stage is read only by the second
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta <= INIT;
      o_sync <= INIT;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule // fswp_sync
`default_nettype wire

// >>> tb/fswp_core_monitor.sv
// Assertion checker for the flash status and write-protect block
`timescale 1ns/1ps
`default_nettype none
module fswp_core_monitor #(
  parameter NV_CYCLES = 200,
  parameter PROG_CYCLES = 200
) (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // Pins and status view
  input wire i_cs_n,
  input wire i_wp_n,
  input wire [7:0] o_status,
  input wire o_array_start,
  input wire [7:0] o_array_op
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  localparam int MIN_BUSY = (PROG_CYCLES < NV_CYCLES) ? PROG_CYCLES : NV_CYCLES;
  int busy_len;
  // Length of the running busy spell
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n)
      busy_len <= 0;
    else
      busy_len <= o_status[0] ? busy_len + 1 : 0;
  end
  a_reserved_zero: assert property (o_status[6] == 1'b0 && o_status[4] == 1'b0)
    else $error("reserved bit set");
  a_start_pulse: assert property (o_array_start |=> !o_array_start)
    else $error("start too long");
  a_start_op: assert property (o_array_start |-> o_array_op inside
    {8'h02, 8'h20, 8'h52, 8'hd8, 8'hc7, 8'h60}) else $error("bad start opcode");
  a_wel_deselect: assert property ($rose(o_status[1]) |-> i_cs_n)
    else $error("latch set in frame");
  a_busy_wel: assert property ($rose(o_status[0]) |-> ##[0:2] !o_status[1])
    else $error("latch kept in cycle");
  a_busy_len: assert property ($fell(o_status[0]) |-> busy_len >= MIN_BUSY)
    else $error("busy too short");
  a_busy_ignore: assert property (o_status[0] |-> !$rose(o_status[1]))
    else $error("command taken while busy");
  a_lock_hold: assert property (o_status[7] && !i_wp_n && !$past(i_wp_n, 4)
    |=> $stable({o_status[7], o_status[5], o_status[3:2]})) else $error("locked bits moved");
  c_busy: cover property ($fell(o_status[0]));
  c_start: cover property (o_array_start);
  c_lock: cover property (o_status[7] && !i_wp_n);
endmodule // fswp_core_monitor
bind fswp_core fswp_core_monitor #(.NV_CYCLES(NV_CYCLES), .PROG_CYCLES(PROG_CYCLES)) mon_u (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_cs_n(i_cs_n), .i_wp_n(i_wp_n), .o_status(o_status),
  .o_array_start(o_array_start), .o_array_op(o_array_op));
`default_nettype wire

// >>> tb/fswp_host_model.sv
// Host serial controller model for the flash command port
`timescale 1ns/1ps
`default_nettype none
module fswp_host_model (
  // Clock
  input wire logic i_clk,
  // Serial port toward the device
  output var logic o_sclk,
  output var logic o_cs_n,
  output var logic o_mosi,
  input wire logic i_miso
);
  // Idle bus: select high, clock parked low
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
  end
  // One framed command, MSB first; rx keeps the last eight bits read back
  task automatic frame(input logic [39:0] d, input int n, output logic [7:0] rx);
    rx = 8'h00;
    o_cs_n <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      o_mosi <= d[i];
      repeat (4) @(posedge i_clk);
      o_sclk <= 1'b1;
      repeat (2) @(posedge i_clk);
      rx = {rx[6:0], i_miso}; // Mid high phase, away from output updates
      repeat (2) @(posedge i_clk);
      o_sclk <= 1'b0;
    end
    repeat (4) @(posedge i_clk);
    o_cs_n <= 1'b1;
    o_mosi <= ~o_mosi; // Released line must not keep its level
    repeat (8) @(posedge i_clk);
  endtask
endmodule // fswp_host_model
`default_nettype wire

// >>> tb/test_fswp_core.sv
// Testbench for the flash status and write-protect block
`timescale 1ns/1ps
`default_nettype none
module test_fswp_core;
  logic clk, rst_n, wp_n, sclk, cs_n, mosi, miso, start, oe;
  logic [7:0] status, op, rx;
  logic [23:0] addr;
  int mismatches = 0;
  int n_checks = 0;
  int n_start, s0, s1;
  int n_oe = 0;
  // Protection table: status, page address, program expected to start
  logic [7:0] sr [7] = '{8'h04, 8'h04, 8'h08, 8'h24, 8'h28, 8'h0c, 8'h20};
  logic [23:0] ad [7] = '{24'h02ff00, 24'h030000, 24'h020000, 24'h00ff00, 24'h020000,
    24'h03ff00, 24'h000000};
  logic ok [7] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
  logic [7:0] er [5] = '{8'h20, 8'h52, 8'hd8, 8'hc7, 8'h60};
  // Clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Program busy time halved to 100 cycles, status-write busy time doubled to 400 cycles
  fswp_core #(.NV_CYCLES(400), .PROG_CYCLES(100)) dut_u (.i_clk(clk), .i_rst_n(rst_n),
    .i_sclk(sclk), .i_cs_n(cs_n), .i_serial_in(mosi), .i_wp_n(wp_n), .o_serial_out(miso),
    .o_serial_out_oe(oe), .o_status(status), .o_array_start(start), .o_array_op(op),
    .o_array_addr(addr));
  fswp_host_model host_u (.i_clk(clk), .o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi),
    .i_miso(miso));
  // Count engine starts and output-enable cycles
  always @(posedge clk) begin
    if (start === 1'b1)
      n_start <= n_start + 1;
    if (oe === 1'b1)
      n_oe <= n_oe + 1;
  end
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cmd(input logic [39:0] d, input int n);
    host_u.frame(d, n, rx);
  endtask
  task automatic rdsr(input logic [7:0] exp, input logic [7:0] m);
    s1 = n_oe;
    host_u.frame(40'h0500, 16, rx);
    chk({16'h0, rx & m}, {16'h0, exp});
    chk({23'h0, n_oe != s1}, 24'h1);
  endtask
  // A busy spell that outlives the limit counts as a mismatch
  task automatic idle;
    for (int k = 0; k < 600 && status[0] !== 1'b0; k++)
      @(posedge clk);
    chk({23'h0, status[0]}, 24'h0);
  endtask
  task automatic t_latch;
    rdsr(8'h00, 8'hff);
    s1 = n_oe;
    cmd(40'h06, 8);
    chk(24'(n_oe - s1), 24'h0);
    rdsr(8'h02, 8'hff);
    cmd(40'h04, 8);
    rdsr(8'h00, 8'hff);
    cmd(40'h012c, 16);
    rdsr(8'h00, 8'hff);
  endtask
  task automatic t_busy;
    wp_n <= 1'b0;
    cmd(40'h06, 8);
    cmd(40'h012c, 15);
    rdsr(8'h02, 8'hff);
    cmd(40'h017c, 16);
    cmd(40'h06, 8);
    rdsr(8'h2d, 8'hff);
    idle();
    rdsr(8'h2c, 8'hff);
  endtask
  task automatic t_protect;
    for (int i = 0; i < 7; i++) begin
      cmd(40'h50, 8);
      cmd({24'h0, 8'h01, sr[i]}, 16);
      rdsr(sr[i], 8'hff);
      cmd(40'h06, 8);
      s0 = n_start;
      cmd({8'h02, ad[i], 8'ha5}, 40);
      idle();
      chk(24'(n_start - s0), {23'h0, ok[i]});
      if (ok[i]) chk(addr, ad[i]);
      chk({23'h0, status[1]}, 24'h0);
    end
  endtask
  task automatic t_erase;
    for (int i = 0; i < 5; i++) begin
      cmd(40'h06, 8);
      s0 = n_start;
      cmd(i < 3 ? {8'h0, er[i], 24'h010000} : {32'h0, er[i]}, i < 3 ? 32 : 8);
      idle();
      chk(24'(n_start - s0), 24'h1);
      chk({16'h0, op}, {16'h0, er[i]});
      if (i < 3) chk(addr, 24'h010000);
    end
  endtask
  task automatic t_lock;
    wp_n <= 1'b1;
    cmd(40'h06, 8);
    cmd(40'h0180, 16);
    idle();
    wp_n <= 1'b0;
    cmd(40'h06, 8);
    cmd(40'h0124, 16);
    idle();
    rdsr(8'h80, 8'hac);
    wp_n <= 1'b1;
    cmd(40'h06, 8);
    cmd(40'h0124, 16);
    idle();
    rdsr(8'h24, 8'hff);
  endtask
  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Main sequence
  initial begin
    rst_n = 1'b0;
    wp_n = 1'b1;
    n_start = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_latch();
    t_busy();
    t_protect();
    t_erase();
    t_lock();
    end_sim();
  end
  // Watchdog, nearly four times the expected run
  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    end_sim();
  end
endmodule // test_fswp_core
`default_nettype wire
